//--- design/ioc_card.v
// I/O card control/flag handshake, diagnose modes and input word FIFO
//
// Function
// - Output instruction loads buffer, device not started
// - Set-control-clear-flag sets control, clears flag
// - Control set drives start with buffered data
// - Device done sets the card flag
// - Interrupt needs flag, control, enable, priority
// - Clear-control-clear-flag idles card, releases priority
// - Skip instruction tests the flag bit
// - Load-input returns device data word
// - Values 1-7 enter diagnose; zero ends it
// - Diagnose entry leaves global register untouched
// - Global register decides which cards accept diagnose
// - Mode 7 blocks service requests until clear
// - Modes 4 to 6 reserved, no behaviour
// - Mode 1 entry withholds priority downstream
// - Priority holder answers scan read, passes on
// - After chain end, scan reads get nothing
// - ID word: smart bit, type, revision, select code
// - Own select code read returns ID undisturbed
// - Mode 2 answers with card status word
// - Mode 3 streams incrementing address by DMA
// - Mode 3 suppresses device start on set-control
// - Reset leaves control and flag cleared
`include "ioc_defs.vh"
`timescale 1ns/10ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides
module ioc_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             i_clk,
	input  wire             i_rst_b,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	// Full and empty come straight from the occupancy count
	assign o_in_ready  = (count_reg != DEPTH[AW:0]);
	assign o_out_valid = (count_reg != {(AW+1){1'b0}});
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage written only on an accepted push
	always @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	// Pointers wrap at the power-of-two depth
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // ioc_fifo

// Card top: instruction decode, handshake, priority chain, diagnose
module ioc_card #(
	parameter [5:0] CARD_TYPE = 6'h01, // Arbitrary neutral value
	parameter [2:0] CARD_REV  = 3'h1,  // Arbitrary neutral value
	parameter       SMART     = 1'b0
) (
	input  wire                    i_clk,
	input  wire                    i_rst_b,
	input  wire                    i_backplane_clear,
	input  wire [`IOC_SC_W-1:0]    i_card_sc,
	input  wire                    i_break_enable,
	input  wire                    i_io_strobe,
	input  wire [`IOC_OP_W-1:0]    i_io_op,
	input  wire [`IOC_SC_W-1:0]    i_io_sc,
	input  wire                    i_io_clear_flag,
	input  wire [`IOC_DATA_W-1:0]  i_io_data,
	output reg  [`IOC_DATA_W-1:0]  o_io_data,
	output reg                     o_io_data_valid,
	output wire                    o_skip,
	input  wire                    i_gr_enable,
	input  wire [`IOC_SC_W-1:0]    i_gr_value,
	input  wire                    i_int_enable,
	input  wire                    i_prio_in,
	output wire                    o_prio_out,
	output wire                    o_irq,
	output reg                     o_dev_start,
	output reg  [`IOC_DATA_W-1:0]  o_dev_data,
	input  wire                    i_dev_done,
	input  wire [`IOC_DATA_W-1:0]  i_dev_data,
	input  wire                    i_dev_srq,
	output wire                    o_srq,
	input  wire [`IOC_DATA_W-1:0]  i_cfg_addr,
	output wire                    o_dma_req,
	output reg  [`IOC_DATA_W-1:0]  o_dma_data,
	input  wire                    i_dma_ack,
	input  wire                    i_dma_count_zero,
	output wire [`IOC_MODE_W-1:0]  o_diag_mode
);
	reg  [`IOC_SC_W-1:0]   sc_reg;
	reg                    control_reg;
	reg                    flag_reg;
	reg  [`IOC_MODE_W-1:0] mode_reg;
	reg                    srq_block_reg;
	reg                    scan_done_reg;
	reg                    dma_run_reg;
	reg  [1:0]             done_sync_reg;
	reg  [1:0]             srq_sync_reg;
	reg  [`IOC_DATA_W-1:0] data_meta_reg;
	reg  [`IOC_DATA_W-1:0] data_sync_reg;
	wire                   own_sel;
	wire                   gr_sel;
	wire                   do_out;
	wire                   do_load;
	wire                   do_set;
	wire                   do_clr;
	wire                   diag_write;
	wire                   diag_zero;
	wire                   diag_enter;
	wire                   gr_match;
	wire                   done_take;
	wire                   fifo_ready;
	wire                   fifo_valid;
	wire [`IOC_DATA_W-1:0] fifo_data;
	wire                   fifo_pop;
	wire                   scan_answer;
	wire                   int_hold;
	wire [`IOC_DATA_W-1:0] id_word;
	wire [`IOC_DATA_W-1:0] status_word;

	// Instruction decode, one cycle per strobe
	assign own_sel    = i_io_strobe && (i_io_sc == sc_reg);
	assign gr_sel     = i_io_strobe && (i_io_sc == `IOC_SC_GLOBAL);
	assign do_out     = own_sel && (i_io_op == `IOC_OP_OUT_ACC);
	assign do_load    = own_sel && (i_io_op == `IOC_OP_LOAD_IN);
	assign do_set     = own_sel && (i_io_op == `IOC_OP_SET_CTL);
	assign do_clr     = own_sel && (i_io_op == `IOC_OP_CLR_CTL);
	assign gr_match   = (i_gr_value == sc_reg);
	assign diag_write = gr_sel && (i_io_op == `IOC_OP_OUT_ACC) && (i_io_data <= `IOC_DIAG_MAX);
	assign diag_zero  = diag_write && (i_io_data[`IOC_MODE_W-1:0] == `IOC_DIAG_OFF);
	assign diag_enter = diag_write && !diag_zero && (!i_gr_enable || gr_match);

	// Skip answer is combinational so the processor sees it in the strobe cycle
	assign o_skip = own_sel && (i_io_op == `IOC_OP_SKIP_FLAG) && flag_reg;

	// Interrupt holding: flag and control set keep priority from lower cards
	assign int_hold   = flag_reg && control_reg;
	assign o_irq      = int_hold && i_int_enable && i_prio_in;
	// Scan modes hold priority back until this card has answered
	assign scan_answer = gr_sel && (i_io_op == `IOC_OP_LOAD_IN) && i_prio_in && !scan_done_reg &&
		((mode_reg == `IOC_DIAG_SCAN) || (mode_reg == `IOC_DIAG_STATUS));
	assign o_prio_out = i_prio_in && !int_hold &&
		!(((mode_reg == `IOC_DIAG_SCAN) || (mode_reg == `IOC_DIAG_STATUS)) && !scan_done_reg);

	// Answer words
	assign id_word = {SMART, CARD_TYPE, CARD_REV, sc_reg};
	assign status_word = {3'h0, i_break_enable, i_prio_in, 1'b0, control_reg, flag_reg,
		gr_match, i_gr_enable, i_gr_value};

	assign o_srq       = srq_sync_reg[1] && !srq_block_reg;
	assign o_dma_req   = dma_run_reg;
	assign o_diag_mode = mode_reg;

	// Strap capture while reset is held; pins pass two flip-flops
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			sc_reg        <= i_card_sc;
			done_sync_reg <= 2'h0;
			srq_sync_reg  <= 2'h0;
			data_meta_reg <= 16'h0000;
			data_sync_reg <= 16'h0000;
		end else begin
			done_sync_reg <= {done_sync_reg[0], i_dev_done};
			srq_sync_reg  <= {srq_sync_reg[0], i_dev_srq};
			data_meta_reg <= i_dev_data;
			data_sync_reg <= data_meta_reg;
		end
	end

	// Done taken only while start is up and the FIFO has room, so back-pressure
	// stalls the device instead of dropping a word
	assign done_take = done_sync_reg[1] && o_dev_start && fifo_ready;
	assign fifo_pop  = do_load && fifo_valid;

	ioc_fifo #(
		.WIDTH (`IOC_DATA_W),
		.DEPTH (`IOC_FIFO_DEPTH),
		.AW    (`IOC_FIFO_AW)
	) u_in_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (done_take),
		.o_in_ready  (fifo_ready),
		.i_in_data   (data_sync_reg),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_data)
	);

	// Control and flag; a done in the clearing cycle still sets the flag
	always @(posedge i_clk) begin
		if (!i_rst_b || i_backplane_clear) begin
			control_reg <= 1'b0;
			flag_reg    <= 1'b0;
		end else begin
			if (do_set) begin
				control_reg <= 1'b1;
			end else if (do_clr) begin
				control_reg <= 1'b0;
			end
			if (done_take) begin
				flag_reg <= 1'b1;
			end else if ((do_set || do_clr) && i_io_clear_flag) begin
				flag_reg <= 1'b0;
			end
		end
	end

	// Output buffer and start handshake toward the device
	always @(posedge i_clk) begin
		if (!i_rst_b || i_backplane_clear) begin
			o_dev_start <= 1'b0;
			o_dev_data  <= 16'h0000;
		end else begin
			if (do_out) begin
				o_dev_data <= i_io_data;
			end
			if (do_set && (mode_reg != `IOC_DIAG_DMA)) begin
				o_dev_start <= 1'b1;
			end else if (done_take || do_clr) begin
				o_dev_start <= 1'b0;
			end
		end
	end

	// Diagnose mode state; control and flag are not touched here
	always @(posedge i_clk) begin
		if (!i_rst_b || i_backplane_clear) begin
			mode_reg      <= `IOC_DIAG_OFF;
			srq_block_reg <= 1'b0;
			scan_done_reg <= 1'b0;
		end else begin
			if (diag_zero) begin
				mode_reg <= `IOC_DIAG_OFF;
			end else if (diag_enter) begin
				mode_reg      <= i_io_data[`IOC_MODE_W-1:0];
				scan_done_reg <= 1'b0;
				if (i_io_data[`IOC_MODE_W-1:0] == `IOC_DIAG_SRQ_OFF) begin
					srq_block_reg <= 1'b1;
				end
			end else if (scan_answer) begin
				scan_done_reg <= 1'b1;
			end
		end
	end

	// Self-test DMA: address source counts up until the engine reports zero
	always @(posedge i_clk) begin
		if (!i_rst_b || i_backplane_clear) begin
			dma_run_reg <= 1'b0;
			o_dma_data  <= 16'h0000;
		end else if (diag_enter && (i_io_data[`IOC_MODE_W-1:0] == `IOC_DIAG_DMA)) begin
			dma_run_reg <= 1'b1;
			o_dma_data  <= i_cfg_addr;
		end else if (diag_zero || i_dma_count_zero) begin
			dma_run_reg <= 1'b0;
		end else if (dma_run_reg && i_dma_ack) begin
			o_dma_data <= o_dma_data + 16'h0001;
		end
	end

	// Read answers one cycle after the strobe; no answer leaves the accumulator alone
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_io_data       <= 16'h0000;
			o_io_data_valid <= 1'b0;
		end else begin
			o_io_data_valid <= 1'b0;
			if (scan_answer) begin
				o_io_data_valid <= 1'b1;
				o_io_data       <= (mode_reg == `IOC_DIAG_SCAN) ? id_word : status_word;
			end else if (do_load && (mode_reg == `IOC_DIAG_SCAN)) begin
				o_io_data_valid <= 1'b1;
				o_io_data       <= id_word;
			end else if (do_load) begin
				o_io_data_valid <= 1'b1;
				o_io_data       <= fifo_valid ? fifo_data : 16'h0000;
			end
		end
	end
endmodule // ioc_card

`default_nettype wire

//--- design/ioc_defs.vh
// Constants for the I/O card control, flag and diagnose logic
`ifndef IOC_DEFS_VH
`define IOC_DEFS_VH

// Instruction codes on the I/O instruction bus
`define IOC_OP_W          3
`define IOC_OP_NONE       3'h0
`define IOC_OP_OUT_ACC    3'h1
`define IOC_OP_LOAD_IN    3'h2
`define IOC_OP_SET_CTL    3'h3
`define IOC_OP_CLR_CTL    3'h4
`define IOC_OP_SKIP_FLAG  3'h5

// Widths and select codes
`define IOC_DATA_W        16
`define IOC_SC_W          6
`define IOC_SC_GLOBAL     6'h02
`define IOC_MODE_W        3

// Diagnose mode values
`define IOC_DIAG_OFF      3'h0
`define IOC_DIAG_SCAN     3'h1
`define IOC_DIAG_STATUS   3'h2
`define IOC_DIAG_DMA      3'h3
`define IOC_DIAG_SRQ_OFF  3'h7
`define IOC_DIAG_MAX      16'h0007

// Identification word fields
`define IOC_ID_SMART_BIT  15
`define IOC_ID_TYPE_HI    14
`define IOC_ID_TYPE_LO    9
`define IOC_ID_REV_HI     8
`define IOC_ID_REV_LO     6

// Status word fields
`define IOC_ST_BREAK_BIT  12
`define IOC_ST_PRIO_BIT   11
`define IOC_ST_CTL_BIT    9
`define IOC_ST_FLAG_BIT   8
`define IOC_ST_MATCH_BIT  7
`define IOC_ST_GREN_BIT   6

// Input buffer shape
`define IOC_FIFO_DEPTH    8
`define IOC_FIFO_AW       3

`endif

//--- tb/ioc_card_chk.sv
// Port-level assertions for the I/O card
`timescale 1ns/10ps
`default_nettype none
`include "ioc_defs.vh"
module ioc_card_chk (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic [5:0]  i_card_sc,
	input wire logic        i_io_strobe,
	input wire logic [2:0]  i_io_op,
	input wire logic [5:0]  i_io_sc,
	input wire logic [15:0] i_io_data,
	input wire logic        i_gr_enable,
	input wire logic [5:0]  i_gr_value,
	input wire logic        i_int_enable,
	input wire logic        i_prio_in,
	input wire logic [15:0] i_cfg_addr,
	input wire logic        o_io_data_valid,
	input wire logic        o_skip,
	input wire logic        o_prio_out,
	input wire logic        o_irq,
	input wire logic        o_dev_start,
	input wire logic [15:0] o_dev_data,
	input wire logic        o_srq,
	input wire logic        o_dma_req,
	input wire logic [15:0] o_dma_data,
	input wire logic [2:0]  o_diag_mode
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Strobe aimed at this card, or a diagnose write this card accepts
	logic own, gr;
	assign own = i_io_strobe && i_io_sc == i_card_sc;
	assign gr  = i_io_strobe && i_io_op == `IOC_OP_OUT_ACC && i_io_sc == 6'h02
		&& (!i_gr_enable || i_gr_value == i_card_sc);
	sequence s_dma_go;
		gr && i_io_data == 16'h0003;
	endsequence
	sequence s_dma_run;
		o_dma_req && o_dma_data == $past(i_cfg_addr);
	endsequence
	a_out_no_start: assert property (own && i_io_op == `IOC_OP_OUT_ACC && !o_dev_start |=>
		!o_dev_start && o_dev_data == $past(i_io_data)) else $error("out-acc misbehaved");
	a_set_starts: assert property (own && i_io_op == `IOC_OP_SET_CTL && o_diag_mode != `IOC_DIAG_DMA |=>
		o_dev_start && $stable(o_dev_data)) else $error("no start after set-control");
	a_dma_no_cmd: assert property (own && i_io_op == `IOC_OP_SET_CTL && o_diag_mode == `IOC_DIAG_DMA
		&& !o_dev_start |=> !o_dev_start) else $error("start in mode 3");
	a_irq_gate: assert property (o_irq |-> i_int_enable && i_prio_in) else $error("irq without enable");
	a_skip_cause: assert property (o_skip |-> own && i_io_op == `IOC_OP_SKIP_FLAG) else $error("stray skip");
	a_diag_enter: assert property (gr && i_io_data != 0 && i_io_data <= `IOC_DIAG_MAX |=>
		o_diag_mode == $past(i_io_data[2:0])) else $error("diag mode not entered");
	a_scan_block: assert property (gr && i_io_data == 16'h0001 |=> !o_prio_out) else $error("prio passed");
	a_load_answer: assert property (own && i_io_op == `IOC_OP_LOAD_IN |=> o_io_data_valid)
		else $error("load-input unanswered");
	a_dma_start: assert property (s_dma_go |=> s_dma_run) else $error("dma run not started");
	a_srq_block: assert property (o_diag_mode == `IOC_DIAG_SRQ_OFF |-> !o_srq) else $error("srq in mode 7");
endmodule // ioc_card_chk
`default_nettype wire

//--- tb/ioc_dev_model.sv
// Behavioural far-side device: four-phase start/done with a data word
`timescale 1ns/10ps
`default_nettype none
module ioc_dev_model (
	input  wire logic        i_clk,
	input  wire logic        i_start,
	input  wire logic [15:0] i_out_data,
	input  wire logic        i_slow,
	output var  logic        o_done,
	output var  logic [15:0] o_data,
	output var  logic [15:0] o_got
);
	logic [15:0] n;
	// Sampled on falling edges so registered outputs have settled
	initial begin
		n = 16'hA500;
		o_done = 0;
		o_data = ~n;
		o_got = 0;
		forever begin
			do @(negedge i_clk); while (!i_start);
			o_got = i_out_data;
			repeat (i_slow ? 12 : 1) @(negedge i_clk);
			o_data = n;
			// Data held three clocks before done so the sync stages agree
			repeat (3) @(negedge i_clk);
			o_done = 1;
			do @(negedge i_clk); while (i_start);
			o_done = 0;
			o_data = ~n; // Released bus shows no stale word
			n++;
		end
	end
endmodule // ioc_dev_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the I/O card
`timescale 1ns/10ps
`default_nettype none
`include "ioc_defs.vh"
module tb;
	localparam [5:0] SC = 6'h0A;
	localparam [15:0] ID = {1'b1, 6'h2D, 3'h5, SC};
	logic clk = 0, rst_b = 0, bpc = 0, stb = 0, clrf = 0, gr_en = 0, int_en = 0, prio_in = 1, brk = 0;
	logic ack = 0, cz = 0, srq_in = 1, slow = 0, rv, sk, skip, prio_out, irq, start, done, service_request, dreq, dvalid;
	logic [2:0] op = 0, mode;
	logic [5:0] sc = 0, gr_val = 0;
	logic [15:0] di = 0, cfg = 0, rd, iodata, odat, ddin, dsrc, got;
	int n_mismatch = 0, cmp_count = 0;
	always #5 clk = ~clk;
	ioc_card #(.CARD_TYPE(6'h2D), .CARD_REV(3'h5), .SMART(1'b1)) dut (.i_clk(clk), .i_rst_b(rst_b),
		.i_backplane_clear(bpc), .i_card_sc(SC), .i_break_enable(brk), .i_io_strobe(stb), .i_io_op(op),
		.i_io_sc(sc), .i_io_clear_flag(clrf), .i_io_data(di), .o_io_data(iodata), .o_io_data_valid(dvalid),
		.o_skip(skip), .i_gr_enable(gr_en), .i_gr_value(gr_val), .i_int_enable(int_en), .i_prio_in(prio_in),
		.o_prio_out(prio_out), .o_irq(irq), .o_dev_start(start), .o_dev_data(odat), .i_dev_done(done),
		.i_dev_data(ddin), .i_dev_srq(srq_in), .o_srq(service_request), .i_cfg_addr(cfg), .o_dma_req(dreq),
		.o_dma_data(dsrc), .i_dma_ack(ack), .i_dma_count_zero(cz), .o_diag_mode(mode));
	ioc_dev_model u_dev (.i_clk(clk), .i_start(start), .i_out_data(odat), .i_slow(slow), .o_done(done),
		.o_data(ddin), .o_got(got));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One instruction; skip sampled in the strobe cycle, answer one cycle on
	task automatic io(input logic [2:0] o, input logic [5:0] s, input logic c, input logic [15:0] d);
		@(negedge clk);
		{stb, op, sc, clrf, di} = {1'b1, o, s, c, d};
		#1 sk = skip;
		@(negedge clk);
		stb = 0;
		rv = dvalid;
		rd = iodata;
	endtask
	task automatic wait_flag;
		sk = 0;
		for (int i = 0; i < 40 && !sk; i++) io(`IOC_OP_SKIP_FLAG, SC, 0, 0);
		chk("flag", sk, 1);
		// Let done fall through the sync stages before the next start
		repeat (4) @(negedge clk);
	endtask
	task automatic t_output;
		io(`IOC_OP_SKIP_FLAG, SC, 0, 0);
		chk("reset flag", sk, 0);
		chk("reset start", start, 0);
		io(`IOC_OP_OUT_ACC, SC, 0, 16'h5A3C);
		chk("out buf", odat, 16'h5A3C);
		chk("no start", start, 0);
		int_en = 1;
		io(`IOC_OP_SET_CTL, SC, 1, 0);
		chk("start", start, 1);
		wait_flag();
		chk("dev got", got, 16'h5A3C);
		chk("irq", irq, 1);
		chk("prio hold", prio_out, 0);
		io(`IOC_OP_OUT_ACC, 2, 0, 4);
		chk("diag keeps ctl", irq, 1);
		io(`IOC_OP_SKIP_FLAG, SC, 0, 0);
		chk("diag keeps flag", sk, 1);
		io(`IOC_OP_OUT_ACC, 2, 0, 0);
		chk("diag left", mode, 0);
		prio_in = 0;
		#1 chk("irq no prio", irq, 0);
		prio_in = 1;
		io(`IOC_OP_SET_CTL, SC, 1, 0);
		io(`IOC_OP_SKIP_FLAG, SC, 0, 0);
		chk("flag cleared", sk, 0);
		wait_flag();
		io(`IOC_OP_CLR_CTL, SC, 1, 0);
		chk("irq off", irq, 0);
		chk("prio free", prio_out, 1);
		io(`IOC_OP_SKIP_FLAG, SC, 0, 0);
		chk("idle flag", sk, 0);
	endtask
	// Two words queued already; six more fill the buffer, the ninth waits
	task automatic t_fifo;
		int_en = 0;
		slow = 1;
		repeat (6) begin
			io(`IOC_OP_SET_CTL, SC, 1, 0);
			wait_flag();
		end
		io(`IOC_OP_SET_CTL, SC, 1, 0);
		repeat (30) @(negedge clk);
		chk("held start", start, 1);
		for (int k = 0; k <= 9; k++) begin
			io(`IOC_OP_LOAD_IN, SC, 0, 0);
			chk("in valid", rv, 1);
			chk("in word", rd, k < 9 ? 16'hA500 + k : 16'h0);
		end
		io(`IOC_OP_CLR_CTL, SC, 1, 0);
	endtask
	task automatic t_diag;
		brk = 1;
		gr_val = SC;
		io(`IOC_OP_OUT_ACC, 2, 0, 1);
		chk("mode1", mode, 1);
		chk("prio cut", prio_out, 0);
		io(`IOC_OP_LOAD_IN, SC, 0, 0);
		chk("own id", rd, ID);
		chk("scan kept", prio_out, 0);
		io(`IOC_OP_LOAD_IN, 2, 0, 0);
		chk("scan id", rd, ID);
		chk("passed", prio_out, 1);
		io(`IOC_OP_LOAD_IN, 2, 0, 0);
		chk("no reply", rv, 0);
		io(`IOC_OP_OUT_ACC, 2, 0, 2);
		io(`IOC_OP_LOAD_IN, 2, 0, 0);
		chk("status", rd, 16'h1880 | SC);
		gr_en = 1;
		gr_val = 6'h11;
		io(`IOC_OP_OUT_ACC, 2, 0, 5);
		chk("gr refuse", mode, 2);
		gr_val = SC;
		for (int m = 4; m < 7; m++) begin
			io(`IOC_OP_OUT_ACC, 2, 0, m[15:0]);
			chk("reserved", mode, m[2:0]);
		end
		cfg = 16'hFFFE;
		io(`IOC_OP_OUT_ACC, 2, 0, 3);
		chk("dma src", dsrc, 16'hFFFE);
		io(`IOC_OP_SET_CTL, SC, 1, 0);
		chk("no cmd", start, 0);
		ack = 1;
		@(negedge clk);
		ack = 0;
		chk("dma inc", dsrc, 16'hFFFF);
		cz = 1;
		@(negedge clk);
		cz = 0;
		@(negedge clk);
		chk("dma end", dreq, 0);
		io(`IOC_OP_OUT_ACC, 2, 0, 0);
		chk("srq pass", service_request, 1);
		io(`IOC_OP_OUT_ACC, 2, 0, 7);
		chk("srq blk", service_request, 0);
		io(`IOC_OP_OUT_ACC, 2, 0, 0);
		chk("mode off", mode, 0);
		chk("srq stays", service_request, 0);
		bpc = 1;
		@(negedge clk);
		bpc = 0;
		@(negedge clk);
		chk("srq back", service_request, 1);
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1;
		t_output();
		t_fifo();
		t_diag();
		close_out();
	end
	// Watchdog: the whole sequence needs well under a tenth of this
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
endmodule // tb
bind ioc_card ioc_card_chk u_chk (.i_clk, .i_rst_b, .i_card_sc, .i_io_strobe, .i_io_op, .i_io_sc, .i_io_data,
	.i_gr_enable, .i_gr_value, .i_int_enable, .i_prio_in, .i_cfg_addr, .o_io_data_valid, .o_skip, .o_prio_out,
	.o_irq, .o_dev_start, .o_dev_data, .o_srq, .o_dma_req, .o_dma_data, .o_diag_mode);
`default_nettype wire
